// ---- stp_chan_if.sv ----
// carrier between the port top and one stepper channel
// assumes both ends run on the one system clock
interface stp_chan_if;
  logic       trig;      // one-cycle shift pulse
  logic       te;        // trigger enable
  logic       mode;      // 1: one-to-two step ring
  logic       dir;       // 1: reverse rotation
  logic       pat;       // pattern generation
  logic       wr;        // data register write
  logic [7:0] wdata;
  logic [3:0] latch;     // output latch
  logic [3:0] alt;       // shift alternate register

  modport top (output trig, te, mode, dir, pat, wr, wdata, input latch, alt);
  modport chan (input trig, te, mode, dir, pat, wr, wdata, output latch, alt);
endinterface : stp_chan_if

// ---- stp_channel.sv ----
// one four-bit stepper / pattern channel: latch and alternate
// assumes a one-cycle shift pulse and a one-cycle write strobe
module stp_channel (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  stp_chan_if.chan   ch
);

  logic [7:0] ring;
  logic [7:0] ring_next;
  logic [3:0] lat_next;
  logic [3:0] alt_next;

  // ring order latch3, alt3, latch2, alt2 ... latch0, alt0
  assign ring = {ch.latch[3], ch.alt[3], ch.latch[2], ch.alt[2],
                 ch.latch[1], ch.alt[1], ch.latch[0], ch.alt[0]};

  // normal rotation carries bit 0 toward bit 3
  assign ring_next = ch.dir ? {ring[0], ring[7:1]} : {ring[6:0], ring[7]};

  // next latch and alternate on a shift
  always_comb begin
    lat_next = ch.latch;
    alt_next = ch.alt;
    if (ch.pat) begin
      lat_next = ch.alt;
    end else if (ch.mode) begin
      lat_next = {ring_next[7], ring_next[5], ring_next[3], ring_next[1]};
      alt_next = {ring_next[6], ring_next[4], ring_next[2], ring_next[0]};
    end else if (ch.dir) begin
      lat_next = {ch.latch[0], ch.latch[3:1]};
    end else begin
      lat_next = {ch.latch[2:0], ch.latch[3]};
    end
  end

  // output latch: a stepper write beats a shift; a blocked pattern write must not eat a trigger
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch.latch <= stp_pkg::RST_LATCH;
    end else if (ch.wr && !ch.pat) begin
      ch.latch <= ch.wdata[stp_pkg::DAT_LATCH_LSB +: 4];
    end else if (ch.trig && ch.te) begin
      ch.latch <= lat_next;
    end
  end

  // alternate register; reset value is not promised to software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch.alt <= stp_pkg::RST_ALT;
    end else if (ch.wr) begin
      ch.alt <= ch.wdata[stp_pkg::DAT_ALT_LSB +: 4];
    end else if (ch.trig && ch.te) begin
      ch.alt <= alt_next;
    end
  end

endmodule : stp_channel

// ---- stp_motor_model.sv ----
// motor driver side of the shared port, pull-ups on every pin
// assumes enable high means the block drives that pin
module stp_motor_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pins float up, so stale drive values never read back
  assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule : stp_motor_model

// ---- stp_pkg.sv ----
// constants shared by the stepper pattern port and its channels
// assumes an 8-bit register bus, each register on an aligned word
package stp_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 10;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CH0_DATA   = 8'h4c;
  localparam logic [7:0] IDX_CH1_DATA   = 8'h4d;
  localparam logic [7:0] IDX_CTRL       = 8'h4e;
  localparam logic [7:0] IDX_PORT_DATA  = 8'h4f;
  localparam logic [7:0] IDX_PORT_DIR   = 8'h50;
  localparam logic [7:0] IDX_PORT_FUNC  = 8'h51;
  localparam logic [7:0] IDX_WIDE_TRIG  = 8'h52;
  localparam logic [7:0] IDX_TRIG_SRC   = 8'h53;

  // control field positions within one channel nibble
  localparam int unsigned CTL_TE        = 0;
  localparam int unsigned CTL_MODE      = 1;
  localparam int unsigned CTL_DIR       = 2;
  localparam int unsigned CTL_PAT       = 3;
  localparam int unsigned CTL_CH1_BASE  = 4;

  // data register layout: latch in the high nibble, alternate low
  localparam int unsigned DAT_LATCH_LSB = 4;
  localparam int unsigned DAT_ALT_LSB   = 0;

  // reset values
  localparam logic [7:0] RST_CTRL       = 8'h00;
  localparam logic [7:0] RST_PORT_DATA  = 8'h00;
  localparam logic [7:0] RST_PORT_DIR   = 8'h00;
  localparam logic [7:0] RST_PORT_FUNC  = 8'h00;
  localparam logic [7:0] RST_WIDE_TRIG  = 8'h70;
  localparam logic [7:0] WIDE_ONES      = 8'h70;
  localparam logic [7:0] RST_TRIG_SRC   = 8'h00;
  localparam logic [3:0] RST_LATCH      = 4'h0;
  localparam logic [3:0] RST_ALT        = 4'h0;

  // trigger source codes, one two-bit field per channel
  localparam logic [1:0] SRC_TIMER0     = 2'h0;
  localparam logic [1:0] SRC_TIMER1     = 2'h1;
  localparam logic [1:0] SRC_WIDE       = 2'h2;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

endpackage : stp_pkg

// ---- stp_port.sv ----
// stepper motor control and pattern generation port, two channels
// assumes timer trigger levels and pins synchronous to clk_sys
// registers on a plain strobe port, read data one cycle later
//
// Summary of operation
// - two four-bit channels share one eight-bit port, four pins each
// - channel zero shifts on timer 0, timer 1 or wide timer 4
// - channel one shifts on timer 0, timer 1 or wide timer 5
// - one control register picks stepper or pattern use per channel
// - channels run independently; settings of one never touch the other
// - reading the port shows the channel latch on pins set to generator and output, pin level on inputs
// - pattern select one: software writes reach the alternate register only
// - pattern mode copies alternate register into latch each trigger
// - port function select chooses generator or port data per pin
// - pattern mode blocks latch writes and overrides both step modes
// - wide timer trigger control bits six to four read as one
// - direction zero shifts bit 0 toward bit 3, one reverses
// - one or two phase: latch rotates once per trigger, alternate ignored
// - one-to-two step: latch and alternate update on trigger rising edge
// - one-to-two step ring order is 7,3,6,2,5,1,4,0
//
// Strobed register access is this design's own decision.
module stp_port (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [stp_pkg::ADDR_W-1:0]  bus_addr,
  input  wire logic [stp_pkg::DATA_W-1:0]  bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic      [stp_pkg::DATA_W-1:0]  bus_rdata,
  input  wire logic                        timer0_trig,
  input  wire logic                        timer1_trig,
  input  wire logic                        timer4_trig,
  input  wire logic                        timer5_trig,
  input  wire logic [7:0]                  port_pin_in,
  output logic      [7:0]                  port_pin_out,
  output logic      [7:0]                  port_pin_oe
);

  // software-visible registers
  logic [7:0] ctrl_reg;        // step_channels_control
  logic [7:0] port_data_reg;   // shared_output_port data
  logic [7:0] port_dir_reg;    // 1: pin drives
  logic [7:0] port_func_reg;   // port_function_select
  logic [7:0] wide_trig_reg;   // wide_timer_trigger_control
  logic [7:0] trig_src_reg;    // trigger source per channel
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // decoded strobes
  logic       hit_ch0;
  logic       hit_ch1;
  logic       hit_ctrl;
  logic       hit_pdata;
  logic       hit_pdir;
  logic       hit_pfunc;
  logic       hit_wide;
  logic       hit_src;

  // write enables, one per register
  logic       we_ch0;
  logic       we_ch1;
  logic       we_ctrl;
  logic       we_pdata;
  logic       we_pdir;
  logic       we_pfunc;
  logic       we_wide;
  logic       we_src;

  // generator bits seen at the port
  logic [7:0] gen_bits;
  logic [7:0] pin_drive;
  logic [7:0] port_view;
  logic       shift0;
  logic       shift1;
  logic       wide0_trig;
  logic       wide1_trig;
  logic [1:0] src0;
  logic [1:0] src1;
  logic [3:0] ctl0;
  logic [3:0] ctl1;
  logic [7:0] ch0_word;
  logic [7:0] ch1_word;
  logic [7:0] wide_view;

  // one carrier per channel module
  stp_chan_if ch0_if ();
  stp_chan_if ch1_if ();

  // register hit, exact match on the byte address
  function automatic logic reg_hit(input logic [stp_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = (a == stp_pkg::addr_of(idx));
  endfunction : reg_hit

  // control nibble of one channel; channel one sits four bits up
  function automatic logic [3:0] ctl_nibble(input logic [7:0] c, input logic sel);
    ctl_nibble = sel ? c[stp_pkg::CTL_CH1_BASE +: 4] : c[3:0];
  endfunction : ctl_nibble

  // address decode, shared by read and write paths
  assign hit_ch0   = reg_hit(bus_addr, stp_pkg::IDX_CH0_DATA);
  assign hit_ch1   = reg_hit(bus_addr, stp_pkg::IDX_CH1_DATA);
  assign hit_ctrl  = reg_hit(bus_addr, stp_pkg::IDX_CTRL);
  assign hit_pdata = reg_hit(bus_addr, stp_pkg::IDX_PORT_DATA);
  assign hit_pdir  = reg_hit(bus_addr, stp_pkg::IDX_PORT_DIR);
  assign hit_pfunc = reg_hit(bus_addr, stp_pkg::IDX_PORT_FUNC);
  assign hit_wide  = reg_hit(bus_addr, stp_pkg::IDX_WIDE_TRIG);
  assign hit_src   = reg_hit(bus_addr, stp_pkg::IDX_TRIG_SRC);

  // write enables; a write to an unmapped address touches nothing
  assign we_ch0   = bus_wr & hit_ch0;
  assign we_ch1   = bus_wr & hit_ch1;
  assign we_ctrl  = bus_wr & hit_ctrl;
  assign we_pdata = bus_wr & hit_pdata;
  assign we_pdir  = bus_wr & hit_pdir;
  assign we_pfunc = bus_wr & hit_pfunc;
  assign we_wide  = bus_wr & hit_wide;
  assign we_src   = bus_wr & hit_src;

  // control register: one nibble per channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= stp_pkg::RST_CTRL;
    end else if (we_ctrl) begin
      ctrl_reg <= bus_wdata;
    end
  end

  // port output data for pins not given to the generator
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_data_reg <= stp_pkg::RST_PORT_DATA;
    end else if (we_pdata) begin
      port_data_reg <= bus_wdata;
    end
  end

  // port direction, starts as input so no pin fights at power up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_dir_reg <= stp_pkg::RST_PORT_DIR;
    end else if (we_pdir) begin
      port_dir_reg <= bus_wdata;
    end
  end

  // per-pin function select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_func_reg <= stp_pkg::RST_PORT_FUNC;
    end else if (we_pfunc) begin
      port_func_reg <= bus_wdata;
    end
  end

  // wide timer trigger control; bits six to four are fixed high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wide_trig_reg <= stp_pkg::RST_WIDE_TRIG;
    end else if (we_wide) begin
      wide_trig_reg <= bus_wdata | stp_pkg::WIDE_ONES;
    end
  end

  // trigger source per channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_src_reg <= stp_pkg::RST_TRIG_SRC;
    end else if (we_src) begin
      trig_src_reg <= bus_wdata;
    end
  end

  // trigger source field of each channel
  assign src0 = trig_src_reg[1:0];
  assign src1 = trig_src_reg[3:2];

  // channel zero pairs with wide timer 4, channel one with wide timer 5
  assign wide0_trig = timer4_trig;
  assign wide1_trig = timer5_trig;

  // channel zero trigger choice
  stp_trig_sel u_sel0 (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .src         (src0),
    .timer0_trig (timer0_trig),
    .timer1_trig (timer1_trig),
    .wide_trig   (wide0_trig),
    .shift_pulse (shift0)
  );

  // channel one trigger choice
  stp_trig_sel u_sel1 (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .src         (src1),
    .timer0_trig (timer0_trig),
    .timer1_trig (timer1_trig),
    .wide_trig   (wide1_trig),
    .shift_pulse (shift1)
  );

  // control nibbles; each channel sees only its own four bits
  assign ctl0 = ctl_nibble(ctrl_reg, 1'b0);
  assign ctl1 = ctl_nibble(ctrl_reg, 1'b1);

  // channel zero takes the low control nibble only
  assign ch0_if.trig  = shift0;
  assign ch0_if.te    = ctl0[stp_pkg::CTL_TE];
  assign ch0_if.mode  = ctl0[stp_pkg::CTL_MODE];
  assign ch0_if.dir   = ctl0[stp_pkg::CTL_DIR];
  assign ch0_if.pat   = ctl0[stp_pkg::CTL_PAT];
  assign ch0_if.wr    = we_ch0;
  assign ch0_if.wdata = bus_wdata;

  // channel one takes the high nibble, so the two stay apart
  assign ch1_if.trig  = shift1;
  assign ch1_if.te    = ctl1[stp_pkg::CTL_TE];
  assign ch1_if.mode  = ctl1[stp_pkg::CTL_MODE];
  assign ch1_if.dir   = ctl1[stp_pkg::CTL_DIR];
  assign ch1_if.pat   = ctl1[stp_pkg::CTL_PAT];
  assign ch1_if.wr    = we_ch1;
  assign ch1_if.wdata = bus_wdata;

  // channel zero datapath, pins 3..0
  stp_channel u_ch0 (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ch      (ch0_if.chan)
  );

  // channel one datapath, pins 7..4
  stp_channel u_ch1 (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ch      (ch1_if.chan)
  );

  // channel zero on pins 3..0, channel one on pins 7..4
  assign gen_bits = {ch1_if.latch, ch0_if.latch};

  // pin mux; any pin may carry generator output
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pin_drive[gi] = port_func_reg[gi] ? gen_bits[gi] : port_data_reg[gi];
    end
    // readback: a driven pin shows its own drive, an input pin its level
    for (gi = 0; gi < 8; gi++) begin : g_view
      assign port_view[gi] = port_dir_reg[gi] ? pin_drive[gi] : port_pin_in[gi];
    end
  endgenerate

  // pins are flop-driven only through the mux, no extra stage
  assign port_pin_out = pin_drive;
  assign port_pin_oe  = port_dir_reg;

  // readback words, latch high and alternate low
  assign ch0_word = {ch0_if.latch, ch0_if.alt};
  assign ch1_word = {ch1_if.latch, ch1_if.alt};

  // wide trigger control readback; fixed bits forced whatever is stored
  assign wide_view = wide_trig_reg | stp_pkg::WIDE_ONES;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit_ch0) begin
      rdata_next = ch0_word;
    end else if (hit_ch1) begin
      rdata_next = ch1_word;
    end else if (hit_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (hit_pdata) begin
      rdata_next = port_view;
    end else if (hit_pdir) begin
      rdata_next = port_dir_reg;
    end else if (hit_pfunc) begin
      rdata_next = port_func_reg;
    end else if (hit_wide) begin
      rdata_next = wide_view;
    end else if (hit_src) begin
      rdata_next = trig_src_reg;
    end
  end

  // read data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // read data leaves straight from the flop
  assign bus_rdata = rdata_reg;

endmodule : stp_port

// ---- stp_port_asserts.sv ----
// concurrent checks on the stepper pattern port, top ports only
// assumes registers change only through the strobe port
module stp_port_asserts (
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic [stp_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [stp_pkg::DATA_W-1:0] bus_wdata,
  input wire logic                       bus_wr,
  input wire logic                       bus_rd,
  input wire logic [stp_pkg::DATA_W-1:0] bus_rdata,
  input wire logic                       timer0_trig,
  input wire logic                       timer1_trig,
  input wire logic                       timer4_trig,
  input wire logic                       timer5_trig,
  input wire logic [7:0]                 port_pin_in,
  input wire logic [7:0]                 port_pin_out,
  input wire logic [7:0]                 port_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] A_CH0  = {stp_pkg::IDX_CH0_DATA, 2'b00};
  localparam logic [9:0] A_CTRL = {stp_pkg::IDX_CTRL, 2'b00};
  localparam logic [9:0] A_DIR  = {stp_pkg::IDX_PORT_DIR, 2'b00};
  localparam logic [9:0] A_FUNC = {stp_pkg::IDX_PORT_FUNC, 2'b00};
  localparam logic [9:0] A_WIDE = {stp_pkg::IDX_WIDE_TRIG, 2'b00};
  localparam logic [9:0] A_SRC  = {stp_pkg::IDX_TRIG_SRC, 2'b00};
  logic [7:0] ctrl_sh;
  logic [7:0] func_sh;
  logic [1:0] src_sh;
  logic [3:0] alt_sh;
  logic       alt_v;
  logic [3:0] tq;
  logic       sel_q;
  logic       sel0;
  logic       rise0;
  logic       rise_any;

  // shadows of what software wrote; alt is trusted only once set in pattern use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_sh <= 8'h00;
      func_sh <= 8'h00;
      src_sh  <= 2'h0;
      alt_sh  <= 4'h0;
      alt_v   <= 1'b0;
    end else if (bus_wr) begin
      if (bus_addr == A_CTRL) ctrl_sh <= bus_wdata;
      if (bus_addr == A_FUNC) func_sh <= bus_wdata;
      if (bus_addr == A_SRC) src_sh <= bus_wdata[1:0];
      if (bus_addr == A_CH0) alt_sh <= bus_wdata[3:0];
      if (bus_addr == A_CH0) alt_v <= ctrl_sh[3];
      if (bus_addr == A_CTRL) alt_v <= 1'b0;
    end
  end

  // trigger history for edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tq    <= 4'h0;
      sel_q <= 1'b0;
    end else begin
      tq    <= {timer5_trig, timer4_trig, timer1_trig, timer0_trig};
      sel_q <= sel0;
    end
  end

  // channel zero source; code 3 selects nothing
  assign sel0 = (src_sh == 2'h0) ? timer0_trig : (src_sh == 2'h1) ? timer1_trig : (src_sh == 2'h2) & timer4_trig;
  assign rise0 = sel0 & ~sel_q;
  assign rise_any = |({timer5_trig, timer4_trig, timer1_trig, timer0_trig} & ~tq);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_rd_idle:
    assert property (!$past(bus_rd) |-> bus_rdata == 8'h00) else $error("read data outside its slot");
  chk_wide_ones:
    assert property (bus_rd && bus_addr == A_WIDE |=> bus_rdata[6:4] == 3'h7) else $error("wide trigger bits not ones");
  chk_reset_clear:
    assert property ($fell(rst) |-> port_pin_out == 8'h00) else $error("pins not clear after reset");
  chk_oe_dir:
    assert property (bus_wr && bus_addr == A_DIR |=> port_pin_oe == $past(bus_wdata)) else $error("pin enable wrong");
  chk_out_quiet:
    assert property (!bus_wr && !rise_any |=> $stable(port_pin_out)) else $error("pins moved with no cause");
  chk_te_hold:
    assert property (!bus_wr && !ctrl_sh[0] |=> $stable(port_pin_out[3:0])) else $error("disabled channel moved");
  chk_ch_indep:
    assert property (!bus_wr && !ctrl_sh[4] |=> $stable(port_pin_out[7:4])) else $error("channel one disturbed");
  chk_rot_step:
    assert property (rise0 && !bus_wr && ctrl_sh[3] == 1'b0 && ctrl_sh[1:0] == 2'h1 && func_sh[3:0] == 4'hf
      |=> port_pin_out[3:0] == ($past(ctrl_sh[2]) ? {$past(port_pin_out[0]), $past(port_pin_out[3:1])}
                                                  : {$past(port_pin_out[2:0]), $past(port_pin_out[3])}))
      else $error("phase rotation wrong");
  chk_pat_copy:
    assert property (rise0 && !bus_wr && ctrl_sh[3] && ctrl_sh[0] && alt_v && func_sh[3:0] == 4'hf
      |=> port_pin_out[3:0] == alt_sh) else $error("pattern not copied");
  chk_pat_block:
    assert property (bus_wr && bus_addr == A_CH0 && ctrl_sh[3] && !rise_any |=> $stable(port_pin_out[3:0]))
      else $error("pattern write reached latch");

  cov_pat: cover property (rise0 && ctrl_sh[3]);
  cov_ring: cover property (rise0 && ctrl_sh[1] && !ctrl_sh[3]);
  cov_wide: cover property (bus_rd && bus_addr == A_WIDE);
endmodule : stp_port_asserts

bind stp_port stp_port_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer0_trig(timer0_trig), .timer1_trig(timer1_trig),
  .timer4_trig(timer4_trig), .timer5_trig(timer5_trig), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe));

// ---- stp_port_test.sv ----
// self-checking bench for the stepper pattern port
// assumes the strobe register port and a motor model on the pins
module stp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys;
  logic       rst;
  logic [9:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic [3:0] tmr;
  logic [7:0] port_pin_in;
  logic [7:0] port_pin_out;
  logic [7:0] port_pin_oe;
  logic [7:0] d;
  int         error_cnt;
  int         n_tests;
  int         cyc;

  stp_port dut_u (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer0_trig(tmr[0]), .timer1_trig(tmr[1]), .timer4_trig(tmr[2]),
    .timer5_trig(tmr[3]), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
  stp_motor_model motor_u (.pin_out(port_pin_out), .pin_oe(port_pin_oe), .pin_in(port_pin_in));

  // 50 ns period
  always #25 clk_sys = ~clk_sys;

  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // hang guard, far above the 143 or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run;
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk_sys);
    bus_addr  <= {idx, 2'b00};
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // read data stand only in the cycle after the strobe edge
  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys);
    bus_addr <= {idx, 2'b00};
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    #1 cmp(nm, e & m, bus_rdata & m);
  endtask : rc

  task automatic pins(input logic [7:0] e, input logic [7:0] m);
    #1 cmp("pins", e & m, port_pin_out & m);
  endtask : pins

  // one trigger pulse with a low cycle after it
  task automatic fire(input int n);
    @(posedge clk_sys);
    tmr[n] <= 1'b1;
    @(posedge clk_sys);
    tmr[n] <= 1'b0;
    @(posedge clk_sys);
  endtask : fire

  // one-to-two step ring: pack, rotate, unpack
  function automatic logic [7:0] ring(input logic [7:0] v, input logic rev);
    logic [7:0] r;
    r = {v[7], v[3], v[6], v[2], v[5], v[1], v[4], v[0]};
    r = rev ? {r[0], r[7:1]} : {r[6:0], r[7]};
    ring = {r[7], r[5], r[3], r[1], r[6], r[4], r[2], r[0]};
  endfunction : ring

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    bus_addr = 10'h000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    tmr = 4'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rc("ctrl", stp_pkg::IDX_CTRL, 8'h00, 8'hff);
    rc("ch0 latch", stp_pkg::IDX_CH0_DATA, 8'h00, 8'hf0);
    rc("ch1 latch", stp_pkg::IDX_CH1_DATA, 8'h00, 8'hf0);
    rc("wide", stp_pkg::IDX_WIDE_TRIG, 8'h70, 8'hff);
    rc("unmapped", 8'h60, 8'h00, 8'hff);
    wr(stp_pkg::IDX_WIDE_TRIG, 8'h0f);
    rc("wide", stp_pkg::IDX_WIDE_TRIG, 8'h7f, 8'hff);
    wr(stp_pkg::IDX_PORT_DIR, 8'hff);
    wr(stp_pkg::IDX_PORT_FUNC, 8'hff);
    // every channel zero source, plus a foreign trigger that must not shift
    for (int s = 0; s < 3; s++) begin
      wr(stp_pkg::IDX_TRIG_SRC, {6'h02, s[1:0]});
      wr(stp_pkg::IDX_CTRL, 8'h01);
      wr(stp_pkg::IDX_CH0_DATA, 8'h10);
      fire(3);
      pins(8'h01, 8'h0f);
      fire(s);
      pins(8'h02, 8'h0f);
    end
    wr(stp_pkg::IDX_CTRL, 8'h05);
    fire(2);
    pins(8'h01, 8'h0f);
    fire(2);
    pins(8'h08, 8'h0f);
    rc("port", stp_pkg::IDX_PORT_DATA, 8'h08, 8'h0f);
    wr(stp_pkg::IDX_CTRL, 8'h04);
    fire(2);
    pins(8'h08, 8'h0f);
    wr(stp_pkg::IDX_CTRL, 8'h03);
    wr(stp_pkg::IDX_CH0_DATA, 8'hc8);
    d = 8'hc8;
    for (int k = 0; k < 4; k++) begin
      wr(stp_pkg::IDX_CTRL, (k == 3) ? 8'h07 : 8'h03);
      fire(2);
      d = ring(d, k == 3);
      rc("ring", stp_pkg::IDX_CH0_DATA, d, 8'hff);
    end
    // pattern use: only the alternate takes writes
    wr(stp_pkg::IDX_CTRL, 8'h0b);
    wr(stp_pkg::IDX_CH0_DATA, 8'h5a);
    rc("pattern", stp_pkg::IDX_CH0_DATA, {d[7:4], 4'ha}, 8'hff);
    fire(2);
    rc("pattern", stp_pkg::IDX_CH0_DATA, 8'haa, 8'hff);
    wr(stp_pkg::IDX_CH0_DATA, 8'h03);
    fire(2);
    pins(8'h03, 8'h0f);
    // channel one from its wide timer, then timer 0 with channel zero idle
    wr(stp_pkg::IDX_CTRL, 8'h1b);
    wr(stp_pkg::IDX_CH1_DATA, 8'h10);
    fire(3);
    pins(8'h23, 8'hff);
    wr(stp_pkg::IDX_TRIG_SRC, 8'h03);
    fire(0);
    pins(8'h43, 8'hff);
    wr(stp_pkg::IDX_PORT_FUNC, 8'h0f);
    wr(stp_pkg::IDX_PORT_DATA, 8'ha0);
    pins(8'ha3, 8'hff);
    wr(stp_pkg::IDX_PORT_DIR, 8'h0f);
    rc("pin in", stp_pkg::IDX_PORT_DATA, 8'hf3, 8'hff);
    cmp("pin enable", 8'h0f, port_pin_oe);
    complete_run;
  end
endmodule : stp_port_test

// ---- stp_trig_sel.sv ----
// trigger source select and rising edge detect for one channel
// assumes timer trigger levels synchronous to clk_sys
module stp_trig_sel (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] src,
  input  wire logic       timer0_trig,
  input  wire logic       timer1_trig,
  input  wire logic       wide_trig,
  output logic            shift_pulse
);

  logic sel_now;
  logic sel_reg;

  // pick the source; unused code gives no trigger
  always_comb begin
    case (src)
      stp_pkg::SRC_TIMER0: sel_now = timer0_trig;
      stp_pkg::SRC_TIMER1: sel_now = timer1_trig;
      stp_pkg::SRC_WIDE:   sel_now = wide_trig;
      default:             sel_now = 1'b0;
    endcase
  end

  // previous level for edge detect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= sel_now;
    end
  end

  // shift only on the rising edge of the chosen trigger
  assign shift_pulse = sel_now & ~sel_reg;

endmodule : stp_trig_sel
